// ### inc/pwr_seq_pkg.sv
// Constants and carrier types for the sequence memory and short detect registers
package pwr_seq_pkg;

   // ==========================================================
   // Clock and timing
   localparam real         CLK_HZ           = 25.0e6;
   localparam real         SCAN_STEP_S      = 0.083;
   localparam int          SCAN_STEP_CYC    = int'(SCAN_STEP_S * CLK_HZ);
   localparam int          SCAN_CNT_W       = 22;

   // ==========================================================
   // Start step pointers
   localparam int          SEQ_N            = 6;
   localparam logic [7:0]  SEQ_OFFS [SEQ_N] = '{8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58};
   localparam logic [5:0]  SEQ_RST  [SEQ_N] = '{6'h04, 6'h0D, 6'h3F, 6'h3F, 6'h3F, 6'h3F};
   localparam int          SEQ_PTR_W        = 6;

   // ==========================================================
   // Sequence memory window
   localparam logic [7:0]  MEM_ADDR_OFF     = 8'h59;
   localparam logic [7:0]  MEM_DATA_OFF     = 8'h5A;
   localparam logic [7:0]  MEM_ADDR_RST     = 8'h00;
   localparam logic [7:0]  MEM_DATA_RST     = 8'h18;
   localparam int          MEM_BYTE_W       = 2;

   // ==========================================================
   // Short detect registers
   localparam logic [7:0]  SETUP_OFF        = 8'h5B;
   localparam logic [7:0]  FLAGS_ONE_OFF    = 8'h5C;
   localparam logic [7:0]  FLAGS_TWO_OFF    = 8'h5D;
   localparam logic [7:0]  IRQ_CHK_OFF      = 8'h5F;
   localparam logic [7:0]  SETUP_RST        = 8'h00;
   localparam logic [7:0]  FLAGS_RST        = 8'h00;
   localparam logic [7:0]  IRQ_CHK_RST      = 8'h00;
   localparam int          SETUP_EN_BIT     = 7;
   localparam int          SETUP_MODE_BIT   = 6;
   localparam int          SETUP_CUT_BIT    = 5;
   localparam int          SEL_W            = 5;
   localparam int          CHK_LIVE_BIT     = 3;
   localparam logic [7:0]  IRQ_CHK_MASK     = 8'h7F;
   localparam logic [7:0]  IRQ_CHK_SYS_CLR  = 8'h0F;
   localparam logic [7:0]  FLAGS_ONE_MASK   = 8'hD2;
   localparam logic [7:0]  FLAGS_TWO_MASK   = 8'hFE;
   localparam logic [7:0]  ONE_SLEEP_MASK   = 8'h92;
   localparam logic [7:0]  ONE_WAITON_MASK  = 8'h40;
   localparam logic [7:0]  TWO_SLEEP_MASK   = 8'h90;
   localparam logic [7:0]  TWO_OFF_MASK     = 8'h60;
   localparam logic [7:0]  TWO_WAITON_MASK  = 8'h0E;

   // ==========================================================
   // Test selector codes
   localparam int          TEST_OUT_N       = 25;
   localparam logic [24:0] TEST_VALID_MASK  = 25'h1F7_FED2;
   localparam logic [4:0]  SEL_PAD_GND      = 5'h1F;
   localparam logic [4:0]  AUTO_FIRST       = 5'h01;
   localparam logic [4:0]  AUTO_LAST        = 5'h0C;

   // ==========================================================
   // Plain storage registers
   localparam int          PLAIN_N          = 36;
   localparam logic [7:0]  PLAIN_OFFS [PLAIN_N] = '{
      8'h5E, 8'h61, 8'h68, 8'h76, 8'h77, 8'h78, 8'h79, 8'h82, 8'h83, 8'h84, 8'h85, 8'h8A,
      8'h8B, 8'h8C, 8'h8D, 8'h96, 8'h97, 8'h98, 8'h99, 8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'h9E,
      8'h9F, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA8, 8'hA9, 8'hAA};
   localparam logic [7:0]  PLAIN_RST [PLAIN_N] = '{
      8'h1F, 8'h00, 8'h12, 8'h00, 8'h00, 8'h08, 8'h09, 8'h00, 8'h00, 8'h08, 8'h02, 8'h20,
      8'h03, 8'h08, 8'h03, 8'h00, 8'h00, 8'h08, 8'h02, 8'hE0, 8'h01, 8'h08, 8'h00, 8'hE0,
      8'h00, 8'h08, 8'h01, 8'hE0, 8'h01, 8'h08, 8'h04, 8'hE0, 8'h02, 8'h08, 8'h00, 8'h00};

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   typedef struct packed {
      logic       strobe;
      logic [7:0] addr;
      logic [7:0] data;
   } mem_wr_s;

   typedef struct packed {
      logic       force_waiton;
      logic [7:0] sleep_one;
      logic [7:0] sleep_two;
      logic [7:0] off_two;
   } cut_req_s;

endpackage : pwr_seq_pkg

// ### logic/level_sync.sv
// Two-stage synchroniser for a bus of independent levels
`timescale 1ns/1ps
module level_sync #(
   parameter int W = 8
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] stage_one;

   // ==========================================================
   // Two flops, first stage read only by the second
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         stage_one <= '0;
         sync_out  <= '0;
      end else begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end

endmodule : level_sync

// ### logic/power_seq_mem_and_short_detect.sv
// Sequence pointers, sequence memory window and short detect registers
`timescale 1ns/1ps
module power_seq_mem_and_short_detect
   import pwr_seq_pkg::*;
#(
   parameter int SCAN_STEP_CYCLES = SCAN_STEP_CYC
) (
   input  wire logic                            clk_sys,
   input  wire logic                            rst_b,
   input  wire logic                            system_reset_n,
   input  wire logic                            key_unlocked,
   input  wire reg_req_s                        reg_req,
   output logic      [7:0]                      reg_rdata,
   input  wire logic [7:0]                      short_live_one,
   input  wire logic [7:0]                      short_live_two,
   output logic      [SEQ_N-1:0][SEQ_PTR_W-1:0] start_step_pointer,
   output mem_wr_s                              mem_wr,
   output cut_req_s                             cut_req,
   output logic      [SEL_W-1:0]                test_output_selector,
   output logic      [TEST_OUT_N-1:0]           test_out_sel,
   output logic                                 test_pad_out,
   output logic                                 test_pad_oe
);

   logic [7:0]             seq_ptr [SEQ_N];
   logic [7:0]             seq_mem_write_pointer;
   logic [7:0]             seq_mem_write_byte;
   logic [7:0]             short_detect_setup;
   logic [7:0]             short_flags_one;
   logic [7:0]             short_flags_two;
   logic [7:0]             irq_check_setup;
   logic [7:0]             plain_reg [PLAIN_N];
   logic [7:0]             live_one;
   logic [7:0]             live_two;
   logic [SEL_W-1:0]       auto_scan_selector;
   logic [SCAN_CNT_W-1:0]  scan_cnt;
   logic                   scan_tick;
   logic                   key_write;
   logic                   wr_one;
   logic                   wr_two;
   logic [7:0]             next_flags_one;
   logic [7:0]             next_flags_two;
   logic [7:0]             next_rdata;
   logic                   auto_shutdown_on_short;
   logic                   live_short_view_select;
   logic [SEL_W-1:0]       sel_eff;

   // ==========================================================
   // Comparator inputs
   level_sync #(.W(16)) u_live_sync (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .async_in ({short_live_two, short_live_one}),
      .sync_out ({live_two, live_one})
   );

   assign auto_shutdown_on_short = short_detect_setup[SETUP_CUT_BIT];
   assign live_short_view_select = irq_check_setup[CHK_LIVE_BIT];

   assign key_write = reg_req.wr & key_unlocked;

   // ==========================================================
   // Start step pointers
   generate
      for (genvar g = 0; g < SEQ_N; g++) begin : g_seq
         always_ff @(posedge clk_sys) begin
            if (!rst_b) begin
               seq_ptr[g] <= {2'b00, SEQ_RST[g]};
            end else if (key_write && reg_req.addr == SEQ_OFFS[g]) begin
               seq_ptr[g] <= reg_req.wdata & 8'h3F;
            end
         end
         assign start_step_pointer[g] = seq_ptr[g][SEQ_PTR_W-1:0];
      end
   endgenerate

   // ==========================================================
   // Sequence memory window
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         seq_mem_write_pointer <= MEM_ADDR_RST;
      end else if (key_write && reg_req.addr == MEM_ADDR_OFF) begin
         seq_mem_write_pointer <= reg_req.wdata;
      end else if (key_write && reg_req.addr == MEM_DATA_OFF) begin
         seq_mem_write_pointer <= seq_mem_write_pointer + 8'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         seq_mem_write_byte <= MEM_DATA_RST;
         mem_wr             <= '0;
      end else begin
         mem_wr.strobe <= key_write && reg_req.addr == MEM_DATA_OFF;
         if (key_write && reg_req.addr == MEM_DATA_OFF) begin
            seq_mem_write_byte <= reg_req.wdata;
            mem_wr.addr        <= seq_mem_write_pointer;
            mem_wr.data        <= reg_req.wdata;
         end
      end
   end

   // ==========================================================
   // Short detect setup and check setup
   always_ff @(posedge clk_sys) begin
      if (!rst_b || !system_reset_n) begin
         short_detect_setup <= SETUP_RST;
      end else if (reg_req.wr && reg_req.addr == SETUP_OFF) begin
         short_detect_setup <= reg_req.wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         irq_check_setup <= IRQ_CHK_RST;
      end else if (!system_reset_n) begin
         irq_check_setup <= irq_check_setup & ~IRQ_CHK_SYS_CLR;
      end else if (reg_req.wr && reg_req.addr == IRQ_CHK_OFF) begin
         irq_check_setup <= reg_req.wdata & IRQ_CHK_MASK;
      end
   end

   // ==========================================================
   // Sticky short flags
   assign wr_one = reg_req.wr && reg_req.addr == FLAGS_ONE_OFF;
   assign wr_two = reg_req.wr && reg_req.addr == FLAGS_TWO_OFF;

   always_comb begin
      next_flags_one = short_flags_one;
      next_flags_two = short_flags_two;
      if (wr_one) begin
         next_flags_one = short_flags_one & reg_req.wdata;
      end
      if (wr_two) begin
         next_flags_two = short_flags_two & reg_req.wdata;
      end
      if (short_detect_setup[SETUP_EN_BIT]) begin
         next_flags_one = next_flags_one | live_one;
         next_flags_two = next_flags_two | live_two;
      end
      next_flags_one = next_flags_one & FLAGS_ONE_MASK;
      next_flags_two = next_flags_two & FLAGS_TWO_MASK;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         short_flags_one <= FLAGS_RST;
         short_flags_two <= FLAGS_RST;
      end else begin
         short_flags_one <= next_flags_one;
         short_flags_two <= next_flags_two;
      end
   end

   // ==========================================================
   // Auto-cut requests
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cut_req <= '0;
      end else if (auto_shutdown_on_short) begin
         cut_req.force_waiton <= |(short_flags_one & ONE_WAITON_MASK)
                               | |(short_flags_two & TWO_WAITON_MASK);
         cut_req.sleep_one    <= short_flags_one & ONE_SLEEP_MASK;
         cut_req.sleep_two    <= short_flags_two & TWO_SLEEP_MASK;
         cut_req.off_two      <= short_flags_two & TWO_OFF_MASK;
      end else begin
         cut_req <= '0;
      end
   end

   // ==========================================================
   // Plain storage registers
   generate
      for (genvar p = 0; p < PLAIN_N; p++) begin : g_plain
         always_ff @(posedge clk_sys) begin
            if (!rst_b) begin
               plain_reg[p] <= PLAIN_RST[p];
            end else if (reg_req.wr && reg_req.addr == PLAIN_OFFS[p]) begin
               plain_reg[p] <= reg_req.wdata;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Automatic selector scan
   assign scan_tick = scan_cnt == SCAN_CNT_W'(SCAN_STEP_CYCLES - 1);

   always_ff @(posedge clk_sys) begin
      if (!rst_b || short_detect_setup[SETUP_MODE_BIT]) begin
         scan_cnt <= '0;
      end else if (scan_tick) begin
         scan_cnt <= '0;
      end else begin
         scan_cnt <= scan_cnt + SCAN_CNT_W'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b || short_detect_setup[SETUP_MODE_BIT]) begin
         auto_scan_selector <= AUTO_FIRST;
      end else if (scan_tick) begin
         if (auto_scan_selector >= AUTO_LAST) begin
            auto_scan_selector <= AUTO_FIRST;
         end else begin
            auto_scan_selector <= auto_scan_selector + 5'h01;
         end
      end
   end

   assign sel_eff = short_detect_setup[SETUP_MODE_BIT] ? short_detect_setup[SEL_W-1:0]
                                                        : auto_scan_selector;

   // ==========================================================
   // Test output decode
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         test_output_selector <= '0;
         test_out_sel         <= '0;
         test_pad_out         <= 1'b0;
         test_pad_oe          <= 1'b0;
      end else begin
         test_output_selector <= sel_eff;
         test_pad_out         <= 1'b0;
         if (sel_eff < SEL_W'(TEST_OUT_N)) begin
            test_out_sel <= (TEST_OUT_N'(1) << sel_eff) & TEST_VALID_MASK;
            test_pad_oe  <= 1'b0;
         end else if (sel_eff == SEL_PAD_GND) begin
            test_out_sel <= '0;
            test_pad_oe  <= 1'b1;
         end else begin
            test_out_sel <= '0;
            test_pad_oe  <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Register read
   always_comb begin
      next_rdata = 8'h00;
      for (int i = 0; i < SEQ_N; i++) begin
         if (reg_req.addr == SEQ_OFFS[i]) begin
            next_rdata = seq_ptr[i] & 8'h3F;
         end
      end
      for (int i = 0; i < PLAIN_N; i++) begin
         if (reg_req.addr == PLAIN_OFFS[i]) begin
            next_rdata = plain_reg[i];
         end
      end
      case (reg_req.addr)
         MEM_ADDR_OFF: begin
            next_rdata = seq_mem_write_pointer;
         end
         MEM_DATA_OFF: begin
            next_rdata = seq_mem_write_byte;
         end
         SETUP_OFF: begin
            next_rdata = short_detect_setup;
         end
         FLAGS_ONE_OFF: begin
            next_rdata = live_short_view_select ? (live_one & FLAGS_ONE_MASK) : short_flags_one;
         end
         FLAGS_TWO_OFF: begin
            next_rdata = live_short_view_select ? (live_two & FLAGS_TWO_MASK) : short_flags_two;
         end
         IRQ_CHK_OFF: begin
            next_rdata = irq_check_setup;
         end
         default: begin
            next_rdata = next_rdata;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_req.rd) begin
         reg_rdata <= next_rdata;
      end
   end

endmodule : power_seq_mem_and_short_detect

// ### tb/host_bus_model.sv
// Host side model driving the internal register port
`timescale 1ns/1ps
module host_bus_model
   import pwr_seq_pkg::*;
(
   input  wire logic [7:0] reg_rdata,
   input  wire logic       clk_sys,
   output reg_req_s        reg_req,
   output logic            key_unlocked
);
   initial begin
      reg_req      = '0;
      key_unlocked = 1'b0;
   end

   // ==========================================================
   // Key control
   // unlock before programming
   task automatic set_key(input logic k);
      @(posedge clk_sys);
      key_unlocked <= k;
   endtask : set_key

   // ==========================================================
   // Bus cycles, address and data scrambled once released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5A};
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
      #1;
      d = reg_rdata;
   endtask : rd
endmodule : host_bus_model

// ### tb/power_seq_mem_and_short_detect_asserts.sv
// Checker for the sequence memory and short detect registers
`timescale 1ns/1ps
module power_seq_mem_and_short_detect_asserts
   import pwr_seq_pkg::*;
#(
   parameter int SCAN_STEP_CYCLES = 8
) (
   input wire logic                            clk_sys,
   input wire logic                            rst_b,
   input wire logic                            system_reset_n,
   input wire logic                            key_unlocked,
   input wire reg_req_s                        reg_req,
   input wire logic      [7:0]                 reg_rdata,
   input wire logic      [7:0]                 short_live_one,
   input wire logic      [7:0]                 short_live_two,
   input wire logic      [SEQ_N-1:0][SEQ_PTR_W-1:0] start_step_pointer,
   input wire mem_wr_s                         mem_wr,
   input wire cut_req_s                        cut_req,
   input wire logic      [SEL_W-1:0]           test_output_selector,
   input wire logic      [TEST_OUT_N-1:0]      test_out_sel,
   input wire logic                            test_pad_out,
   input wire logic                            test_pad_oe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   // ==========================================================
   // Register port
   a_ptr_rsvd_zero: assert property (reg_req.rd && reg_req.addr inside {[8'h53:8'h58]}
      |=> reg_rdata[7:6] == 2'b00) else $error("pointer reserved bits not zero");
   a_ptr_locked_hold: assert property (!key_unlocked |=> $stable(start_step_pointer))
      else $error("pointer changed while locked");
   a_data_strobe: assert property (reg_req.wr && reg_req.addr == MEM_DATA_OFF && key_unlocked
      |=> mem_wr.strobe && mem_wr.data == $past(reg_req.wdata)) else $error("data write gave no strobe");
   a_strobe_cause: assert property (mem_wr.strobe
      |-> $past(reg_req.wr && reg_req.addr == MEM_DATA_OFF && key_unlocked)) else $error("strobe without write");
   a_mem_hold: assert property (!(reg_req.wr && reg_req.addr == MEM_DATA_OFF)
      |=> $stable(mem_wr.addr) && $stable(mem_wr.data)) else $error("memory port moved without write");
   a_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata))
      else $error("read data moved without read");
   a_unmapped_zero: assert property (reg_req.rd && reg_req.addr == 8'h00 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");

   // ==========================================================
   // Test selector outputs
   a_sel_onehot: assert property ($onehot0(test_out_sel)) else $error("test select not one hot");
   a_sel_rsvd_quiet: assert property ((test_out_sel & ~TEST_VALID_MASK) == '0)
      else $error("reserved code drives an output");
   a_pad_to_gnd: assert property ((test_pad_oe == (test_output_selector == SEL_PAD_GND)) && (test_pad_out == 1'b0))
      else $error("test pad drive does not follow code");
endmodule : power_seq_mem_and_short_detect_asserts

bind power_seq_mem_and_short_detect power_seq_mem_and_short_detect_asserts #(
   .SCAN_STEP_CYCLES(SCAN_STEP_CYCLES)
) i_chk (
   .clk_sys(clk_sys), .rst_b(rst_b), .system_reset_n(system_reset_n), .key_unlocked(key_unlocked),
   .reg_req(reg_req), .reg_rdata(reg_rdata), .short_live_one(short_live_one), .short_live_two(short_live_two),
   .start_step_pointer(start_step_pointer), .mem_wr(mem_wr), .cut_req(cut_req),
   .test_output_selector(test_output_selector), .test_out_sel(test_out_sel),
   .test_pad_out(test_pad_out), .test_pad_oe(test_pad_oe)
);

// ### tb/power_seq_mem_and_short_detect_tb_top.sv
// Testbench for the sequence memory and short detect registers
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin failures++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module power_seq_mem_and_short_detect_tb_top
   import pwr_seq_pkg::*;
;
   logic                            clk_sys = 1'b0;
   logic                            rst_b = 1'b0;
   logic                            system_reset_n = 1'b1;
   logic [7:0]                      short_live_one = 8'h00;
   logic [7:0]                      short_live_two = 8'h00;
   reg_req_s                        reg_req;
   logic                            key_unlocked;
   logic [7:0]                      reg_rdata;
   logic [SEQ_N-1:0][SEQ_PTR_W-1:0] start_step_pointer;
   mem_wr_s                         mem_wr;
   cut_req_s                        cut_req;
   logic [SEL_W-1:0]                test_output_selector;
   logic [TEST_OUT_N-1:0]           test_out_sel;
   logic                            test_pad_out;
   logic                            test_pad_oe;
   logic [7:0]                      d;
   int                              failures = 0;
   int                              tests_run = 0;

   always #20 clk_sys = ~clk_sys;

   power_seq_mem_and_short_detect #(.SCAN_STEP_CYCLES(8)) i_dut (
      .clk_sys(clk_sys), .rst_b(rst_b), .system_reset_n(system_reset_n), .key_unlocked(key_unlocked),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .short_live_one(short_live_one),
      .short_live_two(short_live_two), .start_step_pointer(start_step_pointer), .mem_wr(mem_wr),
      .cut_req(cut_req), .test_output_selector(test_output_selector), .test_out_sel(test_out_sel),
      .test_pad_out(test_pad_out), .test_pad_oe(test_pad_oe));
   host_bus_model i_host (.reg_rdata(reg_rdata), .clk_sys(clk_sys), .reg_req(reg_req), .key_unlocked(key_unlocked));

   task automatic stop_test();
      $display("Counts: %0d checks, %0d mismatches", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      `CHK("pointers", {6'h3F, 6'h3F, 6'h3F, 6'h3F, 6'h0D, 6'h04}, start_step_pointer)
      i_host.rd(8'h54, d); `CHK("all_to_waiton", 8'h0D, d)
      i_host.rd(8'h5A, d); `CHK("mem_byte", 8'h18, d)
      i_host.rd(8'h00, d); `CHK("unmapped", 8'h00, d)
      for (int i = 0; i < PLAIN_N; i++) begin
         i_host.rd(PLAIN_OFFS[i], d); `CHK("plain", PLAIN_RST[i], d)
      end
      $display("test reset done");
   endtask : t_reset

   task automatic t_ptr();
      i_host.wr(8'h54, 8'hFF); i_host.rd(8'h54, d); `CHK("locked ptr", 8'h0D, d)
      i_host.set_key(1'b1);
      i_host.wr(8'h54, 8'hFF); i_host.rd(8'h54, d); `CHK("ptr rsvd", 8'h3F, d)
      i_host.wr(8'h58, 8'h2A); #1; `CHK("ptr out", 6'h2A, start_step_pointer[5])
      $display("test pointers done");
   endtask : t_ptr

   task automatic t_mem();
      i_host.wr(8'h59, 8'hFE);
      for (int i = 0; i < 3; i++) begin
         i_host.wr(8'h5A, 8'hA0 + 8'(i)); #1;
         `CHK("strobe", 1'b1, mem_wr.strobe)
         `CHK("mem addr", 8'(8'hFE + i), mem_wr.addr)
         `CHK("mem data", 8'(8'hA0 + i), mem_wr.data)
      end
      i_host.set_key(1'b0);
      i_host.wr(8'h5A, 8'h77); #1; `CHK("locked strobe", 1'b0, mem_wr.strobe)
      i_host.rd(8'h59, d); `CHK("mem ptr", 8'h01, d)
      $display("test memory done");
   endtask : t_mem

   task automatic t_short();
      i_host.wr(8'h5B, 8'hA0);
      @(posedge clk_sys); short_live_one <= 8'hFF; short_live_two <= 8'hFF;
      repeat (6) @(posedge clk_sys);
      short_live_one <= 8'h00; short_live_two <= 8'h00;
      #1; `CHK("waiton", 1'b1, cut_req.force_waiton)
      `CHK("sleep one", 8'h92, cut_req.sleep_one)
      `CHK("off two", 8'h60, cut_req.off_two)
      `CHK("sleep two", 8'h90, cut_req.sleep_two)
      repeat (4) @(posedge clk_sys);
      i_host.rd(8'h5C, d); `CHK("sticky one", 8'hD2, d)
      i_host.rd(8'h5D, d); `CHK("sticky two", 8'hFE, d)
      i_host.wr(8'h5C, 8'h00); i_host.wr(8'h5D, 8'h00);
      i_host.rd(8'h5C, d); `CHK("cleared", 8'h00, d)
      `CHK("cut gone", 1'b0, cut_req.force_waiton)
      i_host.wr(8'h5F, 8'h08);
      @(posedge clk_sys); short_live_one <= 8'h10;
      repeat (5) @(posedge clk_sys);
      i_host.rd(8'h5C, d); `CHK("live view", 8'h10, d)
      @(posedge clk_sys);
      short_live_one <= 8'h00;
      i_host.wr(8'h5F, 8'h00); i_host.wr(8'h5B, 8'h80); i_host.wr(8'h5C, 8'h00);
      @(posedge clk_sys); short_live_one <= 8'h40;
      repeat (6) @(posedge clk_sys);
      #1; `CHK("no cut", 25'h000_0000, cut_req)
      i_host.wr(8'h5F, 8'h08);
      @(posedge clk_sys); system_reset_n <= 1'b0;
      @(posedge clk_sys); system_reset_n <= 1'b1; short_live_one <= 8'h00;
      i_host.rd(8'h5B, d); `CHK("setup sysrst", 8'h00, d)
      i_host.rd(8'h5F, d); `CHK("live sel sysrst", 8'h00, d)
      $display("test short done");
   endtask : t_short

   task automatic t_sel();
      logic [24:0] valid;
      logic [4:0]  prev;
      int          wraps;
      int          gap;
      valid = 25'h1F7_FED2;
      wraps = 0;
      gap = -100;
      for (int c = 0; c < 32; c++) begin
         i_host.wr(8'h5B, 8'h40 | 8'(c));
         repeat (3) @(posedge clk_sys);
         #1; `CHK("selector", 5'(c), test_output_selector)
         `CHK("test out", (c < 25 && valid[c]) ? 25'(1) << c : 25'h000_0000, test_out_sel)
         `CHK("pad oe", c == 31, test_pad_oe)
      end
      repeat (20) @(posedge clk_sys);
      #1; `CHK("sel held", 5'h1F, test_output_selector)
      i_host.wr(8'h5B, 8'h00);
      repeat (3) @(posedge clk_sys);
      #1;
      prev = test_output_selector;
      repeat (200) begin
         @(posedge clk_sys); #1;
         `CHK("scan range", 1'b1, test_output_selector inside {[5'h01:5'h0C]})
         `CHK("scan step", 1'b1, test_output_selector == prev || test_output_selector == prev + 5'h01 ||
            (prev == 5'h0C && test_output_selector == 5'h01))
         if (prev == 5'h0C && test_output_selector == 5'h01) wraps++;
         gap++;
         if (test_output_selector != prev) begin
            if (gap > 0) `CHK("scan period", 8, gap)
            gap = 0;
         end
         prev = test_output_selector;
      end
      `CHK("scan wraps", 1'b1, wraps > 0)
      $display("test selector done");
   endtask : t_sel

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys); #1;
      t_reset();
      t_ptr();
      t_mem();
      t_short();
      t_sel();
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      stop_test();
   end
endmodule : power_seq_mem_and_short_detect_tb_top
